// ---- hw/fpes_pkg.sv ----
/*
 * fpes_pkg: constants, register map, states and carrier structs for the flash
 * program/erase status block.
 * assumes: used with package-qualified names only, nothing is imported.
 */
package fpes_pkg;

	localparam int unsigned CLOCK_HZ = 125_000_000;

	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_GAP_TICKS = 8'h08;
	localparam logic [7:0] OFS_PROG_TIME = 8'h0c;
	localparam logic [7:0] OFS_ERASE_TIME = 8'h10;
	localparam logic [7:0] OFS_FAIL_INJ  = 8'h14;
	localparam logic [7:0] OFS_ID        = 8'h18;

	// control register fields
	localparam int CTL_WIDE_BIT   = 0;
	localparam int CTL_LANE_MODE0 = 1;
	localparam int CTL_LANE_MODE1 = 2;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// lane steering modes
	localparam logic [1:0] LANE_NONE   = 2'h0;
	localparam logic [1:0] LANE_HIGH_EN = 2'h1;
	localparam logic [1:0] LANE_STROBES = 2'h2;

	// status flag positions within the low data byte
	localparam int POLL_POS   = 7;
	localparam int TOGGLE_POS = 6;
	localparam int ERROR_POS  = 5;
	localparam int WINDOW_POS = 3;

	// command words (low byte of the bus)
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE   = 8'h80;
	localparam logic [7:0] CMD_CHIP    = 8'h10;
	localparam logic [7:0] CMD_SECTOR  = 8'h30;
	localparam logic [7:0] CMD_RESET   = 8'hf0;

	// timing defaults in microseconds, converted to clock counts
	localparam int unsigned GAP_US     = 80;
	localparam int unsigned PROG_US    = 10;
	localparam int unsigned ERASE_US   = 1000;
	localparam int unsigned PROG_LIMIT_US = 40;
	localparam logic [31:0] GAP_TICKS_RESET   = 32'(GAP_US * (CLOCK_HZ / 1_000_000));
	localparam logic [31:0] PROG_TIME_RESET   = 32'(PROG_US * (CLOCK_HZ / 1_000_000));
	localparam logic [31:0] ERASE_TIME_RESET  = 32'(ERASE_US * (CLOCK_HZ / 1_000_000));
	localparam logic [31:0] PROG_LIMIT_TICKS  = 32'(PROG_LIMIT_US * (CLOCK_HZ / 1_000_000));

	// arbitrary neutral identity value
	localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_UNL1    = 4'h1,
		ST_UNL2    = 4'h2,
		ST_ERA3    = 4'h3,
		ST_ERA4    = 4'h4,
		ST_ERA5    = 4'h5,
		ST_PROG_WR = 4'h6,
		ST_PROG    = 4'h7,
		ST_ERASE_WIN = 4'h8,
		ST_ERASE   = 4'h9
	} fpes_state_type;

	// one write or read cycle on the host parallel bus
	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [15:0] data;
		logic        high_byte_enable_n;
		logic        low_lane_write_strobe_n;
		logic        high_lane_write_strobe_n;
		logic [7:0]  main_sector_selects;
	} fpes_host_type;

	// one lane-masked write into the array
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0]  lanes;
	} fpes_array_wr_type;

endpackage

// ---- hw/fpes_lane.sv ----
/*
 * fpes_lane: byte-lane steering for a host write.
 * assumes: inputs are the current host cycle; output is combinational.
 */
`timescale 1ns/1ps
module fpes_lane (
	input  wire logic       i_wide,
	input  wire logic [1:0] i_lane_mode,
	input  wire logic       i_addr0,
	input  wire logic       i_high_byte_enable_n,
	input  wire logic       i_low_lane_write_strobe_n,
	input  wire logic       i_high_lane_write_strobe_n,
	output logic      [1:0] o_lanes
);
	always_comb begin
		o_lanes = 2'h0;
		if (!i_wide) begin
			o_lanes = 2'h1;
		end else begin
			case (i_lane_mode)
			fpes_pkg::LANE_HIGH_EN: begin
				if (!i_high_byte_enable_n && !i_addr0)
					o_lanes = 2'h3;
				else if (!i_high_byte_enable_n)
					o_lanes = 2'h2;
				else if (!i_addr0)
					o_lanes = 2'h1;
			end
			fpes_pkg::LANE_STROBES: begin
				o_lanes = {~i_high_lane_write_strobe_n, ~i_low_lane_write_strobe_n};
			end
			default: begin
				// word writes only land on even addresses
				if (!i_addr0)
					o_lanes = 2'h3;
			end
			endcase
		end
	end
endmodule

// ---- hw/fpes_top.sv ----
/*
 * fpes_top: status reporting and write-lane steering for the embedded flash
 * program and erase algorithms, with a small model array for the status reads.
 * assumes: host bus inputs synchronous to i_clock, one cycle per access;
 * axi4-lite master with one write and one read outstanding at most.
 */
`timescale 1ns/1ps
module fpes_top #(
	parameter int DEPTH_LOG2 = 8
) (
	input  wire logic                      i_clock,
	input  wire logic                      i_sys_rst,
	input  wire fpes_pkg::fpes_host_type   i_host,
	output logic                    [15:0] o_read_data,
	output logic                           o_ready_busy_pin,
	input  wire logic               [7:0]  i_s_axi_awaddr,
	input  wire logic                      i_s_axi_awvalid,
	output logic                           o_s_axi_awready,
	input  wire logic               [31:0] i_s_axi_wdata,
	input  wire logic               [3:0]  i_s_axi_wstrb,
	input  wire logic                      i_s_axi_wvalid,
	output logic                           o_s_axi_wready,
	output logic                    [1:0]  o_s_axi_bresp,
	output logic                           o_s_axi_bvalid,
	input  wire logic                      i_s_axi_bready,
	input  wire logic               [7:0]  i_s_axi_araddr,
	input  wire logic                      i_s_axi_arvalid,
	output logic                           o_s_axi_arready,
	output logic                    [31:0] o_s_axi_rdata,
	output logic                    [1:0]  o_s_axi_rresp,
	output logic                           o_s_axi_rvalid,
	input  wire logic                      i_s_axi_rready
);
	localparam int SECT_BITS = 3;

	typedef struct packed {
		fpes_pkg::fpes_state_type state;
		logic [31:0] gap_cnt;
		logic [31:0] run_cnt;
		logic [15:0] target_addr;
		logic [15:0] target_data;
		logic [1:0]  target_lanes;
		logic [7:0]  erase_sectors;
		logic        erase_chip;
		logic        error_flag_bit;
		logic        erase_window_flag;
		logic        toggle_status_bit;
		logic [15:0] read_data;
		logic [31:0] control;
		logic [31:0] gap_ticks;
		logic [31:0] prog_time;
		logic [31:0] erase_time;
		logic [31:0] fail_inj;
		logic        aw_held;
		logic        w_held;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} fpes_regs_type;

	fpes_regs_type r;
	fpes_regs_type next_r;
	logic [15:0] mem [0:(1 << DEPTH_LOG2) - 1];
	logic [1:0]  lanes;
	fpes_pkg::fpes_array_wr_type arr_wr;
	logic [15:0] mem_word;
	logic        wide;

	function automatic logic [SECT_BITS-1:0] sector_of(input logic [15:0] a);
		sector_of = a[DEPTH_LOG2-1 -: SECT_BITS];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	assign wide = r.control[fpes_pkg::CTL_WIDE_BIT];
	assign mem_word = mem[{i_host.addr[DEPTH_LOG2-1:1], i_host.addr[0] & ~wide}];

	fpes_lane u_lane (
		.i_wide                     (wide),
		.i_lane_mode                (r.control[fpes_pkg::CTL_LANE_MODE1:fpes_pkg::CTL_LANE_MODE0]),
		.i_addr0                    (i_host.addr[0]),
		.i_high_byte_enable_n       (i_host.high_byte_enable_n),
		.i_low_lane_write_strobe_n  (i_host.low_lane_write_strobe_n),
		.i_high_lane_write_strobe_n (i_host.high_lane_write_strobe_n),
		.o_lanes                    (lanes)
	);

	always_comb begin
		logic busy;
		logic cmd_wr;
		logic in_erase;
		logic [7:0] cmd;
		logic [15:0] stat;
		logic [31:0] rd;
		busy = 1'b0;
		cmd_wr = 1'b0;
		in_erase = 1'b0;
		cmd = 8'h00;
		stat = 16'h0000;
		rd = 32'h0000_0000;
		next_r = r;
		arr_wr = '0;
		cmd = i_host.data[7:0];
		cmd_wr = i_host.write && (lanes != 2'h0);
		busy = (r.state == fpes_pkg::ST_PROG) || (r.state == fpes_pkg::ST_ERASE)
			|| (r.state == fpes_pkg::ST_ERASE_WIN);

		// command decode; a bad word during an unlock or command sequence returns to array read
		if (cmd_wr && cmd == fpes_pkg::CMD_RESET && !busy) begin
			next_r.state = fpes_pkg::ST_IDLE;
			next_r.error_flag_bit = 1'b0;
		end else begin
			case (r.state)
			fpes_pkg::ST_IDLE:
				if (cmd_wr && cmd == fpes_pkg::CMD_UNLOCK1)
					next_r.state = fpes_pkg::ST_UNL1;
			fpes_pkg::ST_UNL1, fpes_pkg::ST_ERA4:
				if (cmd_wr)
					next_r.state = (cmd == fpes_pkg::CMD_UNLOCK2)
						? ((r.state == fpes_pkg::ST_UNL1) ? fpes_pkg::ST_UNL2 : fpes_pkg::ST_ERA5)
						: fpes_pkg::ST_IDLE;
			fpes_pkg::ST_UNL2:
				if (cmd_wr)
					next_r.state = (cmd == fpes_pkg::CMD_PROGRAM) ? fpes_pkg::ST_PROG_WR
						: (cmd == fpes_pkg::CMD_ERASE) ? fpes_pkg::ST_ERA3 : fpes_pkg::ST_IDLE;
			fpes_pkg::ST_ERA3:
				if (cmd_wr)
					next_r.state = (cmd == fpes_pkg::CMD_UNLOCK1) ? fpes_pkg::ST_ERA4
						: fpes_pkg::ST_IDLE;
			fpes_pkg::ST_ERA5:
				if (cmd_wr) begin
					next_r.state = fpes_pkg::ST_IDLE;
					next_r.run_cnt = 32'h0;
					next_r.gap_cnt = 32'h0;
					next_r.toggle_status_bit = 1'b0;
					next_r.target_addr = i_host.addr;
					if (cmd == fpes_pkg::CMD_CHIP) begin
						next_r.erase_chip = 1'b1;
						next_r.state = fpes_pkg::ST_ERASE;
					end else if (cmd == fpes_pkg::CMD_SECTOR) begin
						next_r.erase_chip = 1'b0;
						next_r.erase_sectors = 8'h1 << sector_of(i_host.addr);
						next_r.erase_window_flag = 1'b0;
						next_r.state = fpes_pkg::ST_ERASE_WIN;
					end
				end
			fpes_pkg::ST_PROG_WR:
				if (cmd_wr) begin
					next_r.target_addr = {i_host.addr[15:1], i_host.addr[0] & ~wide};
					next_r.target_data = i_host.data;
					next_r.target_lanes = lanes;
					next_r.run_cnt = 32'h0;
					next_r.toggle_status_bit = 1'b0;
					next_r.state = fpes_pkg::ST_PROG;
					if (((~mem_word & i_host.data) & {{8{lanes[1]}}, {8{lanes[0]}}}) != 16'h0)
						next_r.error_flag_bit = 1'b1;
				end
			fpes_pkg::ST_PROG: begin
				next_r.run_cnt = r.run_cnt + 32'h1;
				if (r.fail_inj[0] && r.run_cnt >= fpes_pkg::PROG_LIMIT_TICKS) begin
					next_r.error_flag_bit = 1'b1;
					next_r.state = fpes_pkg::ST_IDLE;
				end else if (!r.fail_inj[0] && r.run_cnt >= r.prog_time) begin
					// new data only ands into the word, so bits never rise
					arr_wr.valid = 1'b1;
					arr_wr.addr = r.target_addr;
					arr_wr.data = r.target_data;
					arr_wr.lanes = r.target_lanes;
					next_r.state = fpes_pkg::ST_IDLE;
				end
			end
			fpes_pkg::ST_ERASE_WIN: begin
				next_r.gap_cnt = r.gap_cnt + 32'h1;
				if (cmd_wr && cmd == fpes_pkg::CMD_SECTOR) begin
					next_r.erase_sectors = r.erase_sectors | (8'h1 << sector_of(i_host.addr));
					next_r.erase_window_flag = 1'b1;
					next_r.state = fpes_pkg::ST_ERASE;
				end else if (r.gap_cnt >= r.gap_ticks) begin
					next_r.erase_window_flag = 1'b1;
					next_r.state = fpes_pkg::ST_ERASE;
				end
			end
			fpes_pkg::ST_ERASE: begin
				next_r.run_cnt = r.run_cnt + 32'h1;
				if (r.fail_inj[1] && r.run_cnt >= r.erase_time) begin
					next_r.error_flag_bit = 1'b1;
					next_r.state = fpes_pkg::ST_IDLE;
				end else if (!r.fail_inj[1] && r.run_cnt >= r.erase_time)
					next_r.state = fpes_pkg::ST_IDLE;
			end
			default:
				next_r.state = fpes_pkg::ST_IDLE;
			endcase
		end

		// host reads: whole even-aligned word when wide is set, the addressed word otherwise; lane mode and strobes ignored
		in_erase = r.erase_chip || r.erase_sectors[sector_of(i_host.addr)];
		stat = mem_word;
		if (r.state == fpes_pkg::ST_PROG && i_host.addr[DEPTH_LOG2-1:1]
			== r.target_addr[DEPTH_LOG2-1:1]) begin
			stat[fpes_pkg::POLL_POS] = ~r.target_data[fpes_pkg::POLL_POS];
			stat[fpes_pkg::TOGGLE_POS] = r.toggle_status_bit;
			stat[fpes_pkg::ERROR_POS] = r.error_flag_bit;
			stat[15:8] = 8'h00;
		end else if ((r.state == fpes_pkg::ST_ERASE || r.state == fpes_pkg::ST_ERASE_WIN)
			&& in_erase) begin
			stat[fpes_pkg::POLL_POS] = 1'b0;
			stat[fpes_pkg::TOGGLE_POS] = r.toggle_status_bit;
			stat[fpes_pkg::ERROR_POS] = r.error_flag_bit;
			stat[fpes_pkg::WINDOW_POS] = r.erase_window_flag;
			stat[15:8] = 8'h00;
		end
		if (i_host.read && busy && (i_host.main_sector_selects != 8'h00)) begin
			next_r.toggle_status_bit = ~r.toggle_status_bit;
			next_r.read_data = stat;
		end else if (i_host.read)
			next_r.read_data = stat;
		if (r.state == fpes_pkg::ST_IDLE) begin
			next_r.erase_sectors = 8'h00;
			next_r.erase_chip = 1'b0;
		end

		// axi4-lite write channel: address and data accepted in either order
		if (i_s_axi_awvalid && !r.aw_held) begin
			next_r.aw_held = 1'b1;
			next_r.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !r.w_held) begin
			next_r.w_held = 1'b1;
			next_r.w_data = i_s_axi_wdata;
			next_r.w_strb = i_s_axi_wstrb;
		end
		if (r.aw_held && r.w_held && !r.bvalid) begin
			next_r.aw_held = 1'b0;
			next_r.w_held = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = 2'h0;
			case (r.aw_addr)
			fpes_pkg::OFS_CONTROL:    next_r.control = merge(r.control, r.w_data, r.w_strb);
			fpes_pkg::OFS_GAP_TICKS:  next_r.gap_ticks = merge(r.gap_ticks, r.w_data, r.w_strb);
			fpes_pkg::OFS_PROG_TIME:  next_r.prog_time = merge(r.prog_time, r.w_data, r.w_strb);
			fpes_pkg::OFS_ERASE_TIME: next_r.erase_time = merge(r.erase_time, r.w_data, r.w_strb);
			fpes_pkg::OFS_FAIL_INJ:   next_r.fail_inj = merge(r.fail_inj, r.w_data, r.w_strb);
			fpes_pkg::OFS_STATUS, fpes_pkg::OFS_ID: next_r.bresp = 2'h0;
			default:                  next_r.bresp = 2'h2;
			endcase
		end
		if (r.bvalid && i_s_axi_bready)
			next_r.bvalid = 1'b0;

		// axi4-lite read channel
		if (i_s_axi_arvalid && !r.rvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = 2'h0;
			case (i_s_axi_araddr)
			fpes_pkg::OFS_CONTROL:    rd = r.control;
			fpes_pkg::OFS_STATUS:     rd = {23'h0, r.state, r.erase_window_flag,
				r.toggle_status_bit, r.error_flag_bit, ~busy, busy};
			fpes_pkg::OFS_GAP_TICKS:  rd = r.gap_ticks;
			fpes_pkg::OFS_PROG_TIME:  rd = r.prog_time;
			fpes_pkg::OFS_ERASE_TIME: rd = r.erase_time;
			fpes_pkg::OFS_FAIL_INJ:   rd = r.fail_inj;
			fpes_pkg::OFS_ID:         rd = fpes_pkg::BLOCK_ID;
			default:                  next_r.rresp = 2'h2;
			endcase
			next_r.rdata = rd;
		end else if (r.rvalid && i_s_axi_rready)
			next_r.rvalid = 1'b0;
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r <= '0;
			r.state <= fpes_pkg::ST_IDLE;
			r.erase_window_flag <= 1'b1;
			r.control <= fpes_pkg::CONTROL_RESET;
			r.gap_ticks <= fpes_pkg::GAP_TICKS_RESET;
			r.prog_time <= fpes_pkg::PROG_TIME_RESET;
			r.erase_time <= fpes_pkg::ERASE_TIME_RESET;
		end else begin
			r <= next_r;
		end
	end

	// array model: erase sets sectors to ones, program ands lanes in
	always_ff @(posedge i_clock) begin
		for (int i = 0; i < (1 << DEPTH_LOG2); i++) begin
			if (r.state == fpes_pkg::ST_ERASE && next_r.state == fpes_pkg::ST_IDLE
				&& !r.fail_inj[1] && (r.erase_chip
				|| r.erase_sectors[i[DEPTH_LOG2-1 -: SECT_BITS]]))
				mem[i] <= 16'hffff;
		end
		if (arr_wr.valid) begin
			if (arr_wr.lanes[0])
				mem[arr_wr.addr[DEPTH_LOG2-1:0]][7:0] <= mem[arr_wr.addr[DEPTH_LOG2-1:0]][7:0]
					& arr_wr.data[7:0];
			if (arr_wr.lanes[1])
				mem[arr_wr.addr[DEPTH_LOG2-1:0]][15:8] <= mem[arr_wr.addr[DEPTH_LOG2-1:0]][15:8]
					& arr_wr.data[15:8];
		end
	end

	assign o_read_data = r.read_data;
	assign o_ready_busy_pin = ~((r.state == fpes_pkg::ST_PROG) || (r.state == fpes_pkg::ST_ERASE)
		|| (r.state == fpes_pkg::ST_ERASE_WIN));
	assign o_s_axi_awready = ~r.aw_held;
	assign o_s_axi_wready = ~r.w_held;
	assign o_s_axi_bvalid = r.bvalid;
	assign o_s_axi_bresp = r.bresp;
	assign o_s_axi_arready = ~r.rvalid;
	assign o_s_axi_rvalid = r.rvalid;
	assign o_s_axi_rdata = r.rdata;
	assign o_s_axi_rresp = r.rresp;
endmodule

// ---- testbench/fpes_host_model.sv ----
/*
 * fpes_host_model: host processor on the parallel flash bus, one access per wr call, two per rd2, whole command sequences in prog and erase.
 * assumes: shares the block clock; the sector select is held active throughout.
 */
`timescale 1ns/1ps
module fpes_host_model (
	input  wire logic                    i_clock,
	input  wire logic [15:0]             i_read_data,
	input  wire logic                    i_ready_busy_pin,
	output fpes_pkg::fpes_host_type      o_host
);
	initial begin
		o_host = '0;
		o_host.main_sector_selects = 8'h01;
	end

	// ln is {high byte enable, high strobe, low strobe}, all active low
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [2:0] ln);
		@(posedge i_clock);
		o_host.write <= 1'b1;
		o_host.addr <= a;
		o_host.data <= d;
		{o_host.high_byte_enable_n, o_host.high_lane_write_strobe_n,
			o_host.low_lane_write_strobe_n} <= ln;
		@(posedge i_clock);
		o_host.write <= 1'b0;
		// released data lines do not keep the last value
		o_host.data <= ~d;
	endtask

	// two reads back to back, so a status read sees the toggle move
	task automatic rd2(input logic [15:0] a, output logic [15:0] d0, output logic [15:0] d1);
		@(posedge i_clock);
		o_host.read <= 1'b1;
		o_host.addr <= a;
		@(posedge i_clock);
		#1 d0 = i_read_data;
		@(posedge i_clock);
		o_host.read <= 1'b0;
		#1 d1 = i_read_data;
	endtask

	task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic [2:0] ln);
		wr(16'h0000, 16'h00aa, 3'h0);
		wr(16'h0000, 16'h0055, 3'h0);
		wr(16'h0000, 16'h00a0, 3'h0);
		wr(a, d, ln);
	endtask

	task automatic erase(input logic [15:0] a, input logic [7:0] code);
		wr(16'h0000, 16'h00aa, 3'h0);
		wr(16'h0000, 16'h0055, 3'h0);
		wr(16'h0000, 16'h0080, 3'h0);
		wr(16'h0000, 16'h00aa, 3'h0);
		wr(16'h0000, 16'h0055, 3'h0);
		wr(a, {8'h00, code}, 3'h0);
	endtask

	task automatic finish(input logic [15:0] a, input int lim, output logic ok);
		logic [15:0] s0;
		logic [15:0] s1;
		ok = 1'b0;
		for (int n = 0; n < lim && !ok; n++) begin
			rd2(a, s0, s1);
			if (s1[5]) rd2(a, s0, s1);
			ok = i_ready_busy_pin;
		end
	endtask
endmodule

// ---- testbench/fpes_top_properties.sv ----
/*
 * fpes_top_properties: host-bus checks bound into fpes_top.
 * assumes: while busy the bench reads only the word under operation.
 */
`timescale 1ns/1ps
module fpes_top_checker (
	input wire logic                    i_clock,
	input wire logic                    i_sys_rst,
	input wire fpes_pkg::fpes_host_type i_host,
	input wire logic [15:0]             o_read_data,
	input wire logic                    o_ready_busy_pin
);
	logic [39:0] hist;
	logic [15:0] paddr;
	logic [7:0]  pbyte;
	logic        erasing;
	logic        stat_q;
	logic        err_seen;
	logic        full_wr;
	logic        prog_go;
	logic        era_go;
	logic        rd_busy;
	// partial-lane writes are left out: whether they start depends on the lane mode
	assign full_wr = i_host.write && !i_host.addr[0] && !i_host.high_byte_enable_n
		&& !i_host.low_lane_write_strobe_n && !i_host.high_lane_write_strobe_n;
	assign prog_go = full_wr && hist[23:0] == 24'haa55a0;
	assign era_go  = full_wr && hist == 40'haa5580aa55 && i_host.data[7:0] inside {8'h10, 8'h30};
	assign rd_busy = i_host.read && !o_ready_busy_pin && i_host.main_sector_selects != 8'h00;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hist     <= 40'h0;
			paddr    <= 16'h0;
			pbyte    <= 8'h0;
			erasing  <= 1'b0;
			stat_q   <= 1'b0;
			err_seen <= 1'b0;
		end else begin
			if (i_host.write) hist <= {hist[31:0], i_host.data[7:0]};
			if (prog_go) begin
				paddr   <= i_host.addr;
				pbyte   <= i_host.data[7:0];
				erasing <= 1'b0;
			end
			if (era_go) erasing <= 1'b1;
			stat_q <= rd_busy;
			if (stat_q && o_read_data[5]) err_seen <= 1'b1;
			if (i_host.write && o_ready_busy_pin && i_host.data[7:0] == 8'hf0) err_seen <= 1'b0;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	property p_prog_busy; prog_go |=> !o_ready_busy_pin; endproperty
	property p_era_busy; era_go |=> !o_ready_busy_pin; endproperty
	property p_idle_ready; o_ready_busy_pin && !i_host.write |=> o_ready_busy_pin; endproperty
	property p_toggle;
		rd_busy ##1 rd_busy |=> o_read_data[6] != $past(o_read_data[6]);
	endproperty
	property p_read_hold; !i_host.read |=> $stable(o_read_data); endproperty
	property p_poll_prog;
		rd_busy && !erasing && i_host.addr == paddr |=> o_read_data[7] == ~pbyte[7];
	endproperty
	property p_poll_erase; rd_busy && erasing |=> o_read_data[7] == 1'b0; endproperty
	property p_upper; rd_busy |=> o_read_data[15:8] == 8'h00; endproperty
	property p_err_hold; rd_busy && err_seen |=> o_read_data[5]; endproperty
	a_prog_busy: assert property (p_prog_busy) else $error("no busy after program");
	a_era_busy: assert property (p_era_busy) else $error("no busy after erase");
	a_idle_ready: assert property (p_idle_ready) else $error("busy with no command");
	a_toggle: assert property (p_toggle) else $error("toggle bit did not flip");
	a_read_hold: assert property (p_read_hold) else $error("read data moved");
	a_poll_prog: assert property (p_poll_prog) else $error("poll bit wrong");
	a_poll_erase: assert property (p_poll_erase) else $error("erase poll not 0");
	a_upper: assert property (p_upper) else $error("status upper byte set");
	a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
	c_prog: cover property (prog_go);
	c_erase: cover property (era_go);
	c_err: cover property ($rose(err_seen));
endmodule

bind fpes_top fpes_top_checker u_checker (
	.i_clock          (i_clock),
	.i_sys_rst        (i_sys_rst),
	.i_host           (i_host),
	.o_read_data      (o_read_data),
	.o_ready_busy_pin (o_ready_busy_pin)
);

// ---- testbench/fpes_top_tb.sv ----
/*
 * fpes_top_tb: table of lane cases, then error, time-out, erase and reset cases.
 * assumes: fpes_host_model drives the host bus; this module is the axi4-lite master.
 */
`timescale 1ns/1ps
module fpes_top_tb;
	typedef struct packed {
		logic        wide;
		logic [1:0]  mode;
		logic [2:0]  ln;
		logic [15:0] a;
		logic [15:0] d;
		logic [15:0] exp;
	} fpes_row_type;
	logic                    clock;
	logic                    sys_rst;
	fpes_pkg::fpes_host_type host;
	logic [15:0]             read_data;
	logic                    ready_busy;
	logic [7:0]              awaddr;
	logic                    awvalid;
	logic                    awready;
	logic [31:0]             wdata;
	logic                    wvalid;
	logic                    wready;
	logic [1:0]              bresp;
	logic                    bvalid;
	logic                    bready;
	logic [7:0]              araddr;
	logic                    arvalid;
	logic                    arready;
	logic [31:0]             rdata;
	logic [1:0]              rresp;
	logic                    rvalid;
	logic                    rready;
	int                      errors = 0;
	int                      cmp_count = 0;
	int                      cyc = 0;
	fpes_row_type            rows [10] = '{
		'{1'b0, 2'h0, 3'h0, 16'h00a1, 16'h00a5, 16'h00a5},
		'{1'b0, 2'h0, 3'h0, 16'h00a2, 16'h00a3, 16'h00a3},
		'{1'b1, 2'h0, 3'h0, 16'h0030, 16'h1234, 16'h1234},
		'{1'b1, 2'h0, 3'h0, 16'h0033, 16'h0000, 16'hffff},
		'{1'b1, 2'h1, 3'h0, 16'h0040, 16'h5678, 16'h5678},
		'{1'b1, 2'h1, 3'h0, 16'h0043, 16'h1212, 16'h12ff},
		'{1'b1, 2'h1, 3'h4, 16'h0044, 16'h3434, 16'hff34},
		'{1'b1, 2'h2, 3'h0, 16'h0050, 16'h9abc, 16'h9abc},
		'{1'b1, 2'h2, 3'h1, 16'h0052, 16'h5656, 16'h56ff},
		'{1'b1, 2'h2, 3'h2, 16'h0054, 16'h7878, 16'hff78}
	};

	fpes_top #(.DEPTH_LOG2(8)) DUT (
		.i_clock(clock), .i_sys_rst(sys_rst), .i_host(host), .o_read_data(read_data),
		.o_ready_busy_pin(ready_busy), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready)
	);
	fpes_host_model hm (
		.i_clock(clock), .i_read_data(read_data), .i_ready_busy_pin(ready_busy), .o_host(host)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		logic tr;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge clock);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = bvalid;
			r = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) break;
		end
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tr;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge clock);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		logic [31:0] v;
		logic [1:0]  rs;
		logic [15:0] s0;
		logic [15:0] s1;
		logic        ok;
		sys_rst = 1'b1;
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		axr(fpes_pkg::OFS_CONTROL, v, rs);
		chk("control reset", v, fpes_pkg::CONTROL_RESET);
		axr(fpes_pkg::OFS_ID, v, rs);
		chk("id", v, fpes_pkg::BLOCK_ID);
		axr(8'h1c, v, rs);
		chk("unmapped rresp", {30'h0, rs}, 32'h2);
		axw(8'h1c, 32'h0, rs);
		chk("unmapped bresp", {30'h0, rs}, 32'h2);
		// short timings keep the run brief
		axw(fpes_pkg::OFS_GAP_TICKS, 32'h14, rs);
		axw(fpes_pkg::OFS_PROG_TIME, 32'h14, rs);
		axw(fpes_pkg::OFS_ERASE_TIME, 32'h14, rs);
		axw(fpes_pkg::OFS_CONTROL, 32'h1, rs);
		hm.erase(16'h0000, 8'h10);
		hm.finish(16'h0000, 200, ok);
		$display("test setup done");
		foreach (rows[i]) begin
			axw(fpes_pkg::OFS_CONTROL, {29'h0, rows[i].mode, rows[i].wide}, rs);
			hm.prog(rows[i].a, rows[i].d, rows[i].ln);
			hm.finish(rows[i].a, 100, ok);
			chk("row done", {31'h0, ok}, 32'h1);
			hm.rd2(rows[i].wide ? {rows[i].a[15:1], 1'b0} : rows[i].a, s0, s1);
			s1 = s1 & (rows[i].wide ? 16'hffff : 16'h00ff);
			chk("row word", {16'h0, s1}, {16'h0, rows[i].exp});
			hm.wr(16'h0000, 16'h00f0, 3'h0);
		end
		$display("test lane table done");
		axw(fpes_pkg::OFS_CONTROL, 32'h1, rs);
		hm.prog(16'h0030, 16'hffff, 3'h0);
		@(negedge clock);
		chk("busy pin", {31'h0, ready_busy}, 32'h0);
		hm.finish(16'h0030, 100, ok);
		axr(fpes_pkg::OFS_STATUS, v, rs);
		chk("error set", {31'h0, v[2]}, 32'h1);
		hm.rd2(16'h0030, s0, s1);
		chk("bits stay 0", {16'h0, s1}, 32'h1234);
		// later work stays out of the failed sector
		hm.prog(16'h0064, 16'h00ff, 3'h0);
		hm.finish(16'h0064, 100, ok);
		axr(fpes_pkg::OFS_STATUS, v, rs);
		chk("error kept", {31'h0, v[2]}, 32'h1);
		hm.wr(16'h0000, 16'h00f0, 3'h0);
		axr(fpes_pkg::OFS_STATUS, v, rs);
		chk("error cleared", {31'h0, v[2]}, 32'h0);
		axw(fpes_pkg::OFS_FAIL_INJ, 32'h1, rs);
		hm.prog(16'h0088, 16'h0f0f, 3'h0);
		hm.finish(16'h0088, 2500, ok);
		axr(fpes_pkg::OFS_STATUS, v, rs);
		chk("time-out error", {31'h0, v[2]}, 32'h1);
		hm.wr(16'h0000, 16'h00f0, 3'h0);
		axw(fpes_pkg::OFS_FAIL_INJ, 32'h0, rs);
		$display("test program errors done");
		hm.erase(16'h0040, 8'h30);
		hm.rd2(16'h0044, s0, s1);
		chk("window early", {31'h0, s0[3]}, 32'h0);
		chk("erase poll", {31'h0, s0[7]}, 32'h0);
		chk("toggle", {31'h0, s1[6]}, {31'h0, ~s0[6]});
		repeat (25) @(posedge clock);
		hm.rd2(16'h0044, s0, s1);
		chk("window late", {31'h0, s1[3]}, 32'h1);
		hm.finish(16'h0044, 100, ok);
		hm.rd2(16'h0040, s0, s1);
		chk("sector erased", {16'h0, s1}, 32'hffff);
		hm.rd2(16'h0030, s0, s1);
		chk("other sector kept", {16'h0, s1}, 32'h1234);
		$display("test sector erase done");
		hm.prog(16'h0094, 16'h1111, 3'h0);
		@(posedge clock);
		sys_rst <= 1'b1;
		@(negedge clock);
		chk("reset ready", {31'h0, ready_busy}, 32'h1);
		chk("reset read data", {16'h0, read_data}, 32'h0);
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		axr(fpes_pkg::OFS_GAP_TICKS, v, rs);
		chk("gap reset", v, fpes_pkg::GAP_TICKS_RESET);
		$display("test reset done");
		print_verdict();
	end
endmodule
